// >>> hw/convert_strobe_link_consts.svh
// timing counts, frame layout and power-down pulse counts of the converter link
`ifndef CONVERT_STROBE_LINK_CONSTS_SVH
`define CONVERT_STROBE_LINK_CONSTS_SVH

`define CORE_PERIOD_NS  50
`define FRAME_BITS      6'd32
`define LAST_BIT        6'd31
`define CODE_BITS       14
`define NARROW_BITS     12
`define NAP_PULSES      3'd2
`define SLEEP_PULSES    3'd4
`define PULSE_CNT_MAX   3'd7
`define SCK_HALF_CYC    4'd8
`define PD_PULSE_CYC    4'd2
`define THROUGHPUT_NS   667
`define THROUGHPUT_CYC  5'((`THROUGHPUT_NS + `CORE_PERIOD_NS - 1) / `CORE_PERIOD_NS)
`define ACQ_NS          45
`define ACQ_CYC         4'((`ACQ_NS + `CORE_PERIOD_NS - 1) / `CORE_PERIOD_NS)
`define SETTLE_MS       2
`define SETTLE_CYC      (`SETTLE_MS * 1000000 / `CORE_PERIOD_NS)

`endif

// >>> hw/convert_strobe_link_pkg.sv
// types shared by both ends of the converter link
package convert_strobe_link_pkg;

  typedef enum {
    pwr_run,
    pwr_nap,
    pwr_sleep
  } pwr_mode_t;

  typedef enum {
    h_idle,
    h_lead,
    h_high,
    h_low,
    h_acq,
    h_pd_hi,
    h_pd_lo,
    h_wake_hi,
    h_wake_lo,
    h_settle
  } host_state_t;

  typedef logic [13:0] code_t;
  typedef logic [31:0] frame_t;

endpackage : convert_strobe_link_pkg

// >>> hw/convert_strobe_link_if.sv
// three-wire link between the converter and its host controller
interface convert_strobe_link_if;
  logic convert_strobe;
  logic serial_clk;
  logic serial_result_out;
  logic serial_result_oe_n;
  wire  serial_line;

  // released line reads the inverse of the idle data level, so a stale bit cannot pass
  assign serial_line = serial_result_out ^ serial_result_oe_n;

  modport adc (
    input  convert_strobe,
    input  serial_clk,
    output serial_result_out,
    output serial_result_oe_n
  );

  modport ctrl (
    output convert_strobe,
    output serial_clk,
    input  serial_line
  );
endinterface : convert_strobe_link_if

// >>> hw/adc_end.sv
// converter end: strobe sampling, serial readout and power-down detection
// What this block does
// - strobe rise holds both channels, starts conversion
// - each clock rise advances conversion, next bit
// - acquisition runs from 32nd rise to strobe
// - strobe too close to clock: data one later
// - host raises strobe half clock before rise
// - three-state output, results of previous conversion
// - host captures each bit on clock rise
// - two strobes, clock steady: nap
// - four or more strobes, clock steady: sleep
// - clock pulses wake the device
// - host waits settle time after wake from sleep
// - conversion strobe rises at least 667 ns apart
// - clock period 19.6 ns to 10000 ns
// - results are 14 or 12 bits
// - over range all ones, under zero zeros
// - nap and sleep have no pin
`include "convert_strobe_link_consts.svh"

// ----------------------------------------
// channel frame half: clamp and justify
// ----------------------------------------
module chan_half #(
  parameter bit WIDE_RES = 1'b1
) (
  input  wire convert_strobe_link_pkg::code_t code,
  input  wire logic                 over_range,
  input  wire logic                 under_range,
  output logic [15:0]               half
);
  import convert_strobe_link_pkg::*;
  code_t clamped;

  always_comb begin
    clamped = code;
    if (over_range) begin
      clamped = '1;
    end else if (under_range) begin
      clamped = '0;
    end
    if (WIDE_RES) begin
      half = {2'b00, clamped};
    end else begin
      half = {2'b00, clamped[`NARROW_BITS-1:0], 2'b00};
    end
  end
endmodule : chan_half

// ----------------------------------------
// converter end
// ----------------------------------------
module adc_end #(
  parameter bit WIDE_RES = 1'b1
) (
  input  wire logic                 core_clk,
  input  wire logic                 rst,
  convert_strobe_link_if.adc                  link,
  input  wire convert_strobe_link_pkg::code_t ch0_code,
  input  wire convert_strobe_link_pkg::code_t ch1_code,
  input  wire logic                 ch0_over,
  input  wire logic                 ch0_under,
  input  wire logic                 ch1_over,
  input  wire logic                 ch1_under,
  output logic                      sample_taken
);
  import convert_strobe_link_pkg::*;

  // ----------------------------------------
  // pin synchronisers and edge detection
  // ----------------------------------------
  logic [1:0] convert_strobe_sync_q;
  logic [1:0] sck_sync_q;
  logic       convert_strobe_prev_q;
  logic       sck_prev_q;
  logic       convert_strobe_rise;
  logic       sck_rise;
  logic       sck_edge;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      convert_strobe_sync_q <= 2'b00;
      sck_sync_q  <= 2'b00;
      convert_strobe_prev_q <= 1'b0;
      sck_prev_q  <= 1'b0;
    end else begin
      convert_strobe_sync_q <= {convert_strobe_sync_q[0], link.convert_strobe};
      sck_sync_q  <= {sck_sync_q[0], link.serial_clk};
      convert_strobe_prev_q <= convert_strobe_sync_q[1];
      sck_prev_q  <= sck_sync_q[1];
    end
  end

  assign convert_strobe_rise = convert_strobe_sync_q[1] & ~convert_strobe_prev_q;
  assign sck_rise  = sck_sync_q[1] & ~sck_prev_q;
  assign sck_edge  = sck_sync_q[1] ^ sck_prev_q;

  // ----------------------------------------
  // live frame from the inputs
  // ----------------------------------------
  logic [15:0] half0;
  logic [15:0] half1;

  chan_half #(.WIDE_RES(WIDE_RES)) u_half0 (
    .code        (ch0_code),
    .over_range  (ch0_over),
    .under_range (ch0_under),
    .half        (half0)
  );

  chan_half #(.WIDE_RES(WIDE_RES)) u_half1 (
    .code        (ch1_code),
    .over_range  (ch1_over),
    .under_range (ch1_under),
    .half        (half1)
  );

  // ----------------------------------------
  // conversion, readout and power state
  // ----------------------------------------
  pwr_mode_t  mode_q,      mode_d;
  logic [2:0] pulses_q,    pulses_d;
  logic [5:0] bit_cnt_q,   bit_cnt_d;
  logic       framing_q,   framing_d;
  logic       late_q,      late_d;
  frame_t     held_q,      held_d;
  frame_t     result_q,    result_d;
  frame_t     shift_q,     shift_d;
  logic       out_q,       out_d;
  logic       oe_n_q,      oe_n_d;
  logic       taken_q,     taken_d;
  logic [2:0] pulses_next;

  always_comb begin
    mode_d      = mode_q;
    pulses_d    = pulses_q;
    bit_cnt_d   = bit_cnt_q;
    framing_d   = framing_q;
    late_d      = late_q;
    held_d      = held_q;
    result_d    = result_q;
    shift_d     = shift_q;
    out_d       = out_q;
    oe_n_d      = oe_n_q;
    taken_d     = 1'b0;
    pulses_next = 3'd1;
    if (!sck_edge) begin
      pulses_next = (pulses_q == `PULSE_CNT_MAX) ? pulses_q : pulses_q + 3'd1;
    end
    if (sck_edge) begin
      pulses_d = 3'd0;
    end
    if (sck_rise && mode_q != pwr_run) begin
      // wake edge only; it does not clock a frame
      mode_d = pwr_run;
    end else if (convert_strobe_rise) begin
      pulses_d = pulses_next;
      if (pulses_next >= `SLEEP_PULSES) begin
        mode_d = pwr_sleep;
      end else if (pulses_next >= `NAP_PULSES) begin
        mode_d = pwr_nap;
      end
      if (mode_q == pwr_run && pulses_next < `NAP_PULSES) begin
        held_d    = {half0, half1};
        shift_d   = result_q;
        out_d     = result_q[31];
        oe_n_d    = 1'b0;
        // the acquisition window closes at this strobe
        bit_cnt_d = 6'd0;
        framing_d = 1'b1;
        taken_d   = 1'b1;
        // same-cycle clock rise means the setup was missed
        late_d    = sck_rise;
      end else begin
        framing_d = 1'b0;
        oe_n_d    = 1'b1;
      end
    end else if (sck_rise && framing_q) begin
      if (late_q) begin
        late_d = 1'b0;
      end else begin
        bit_cnt_d = bit_cnt_q + 6'd1;
        shift_d   = {shift_q[30:0], 1'b0};
        out_d     = shift_q[30];
        if (bit_cnt_q == `LAST_BIT) begin
          framing_d = 1'b0;
          oe_n_d    = 1'b1;
          result_d  = held_q;
          out_d     = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      mode_q    <= pwr_run;
      pulses_q  <= 3'd0;
      bit_cnt_q <= 6'd0;
      framing_q <= 1'b0;
      late_q    <= 1'b0;
      held_q    <= '0;
      result_q  <= '0;
      shift_q   <= '0;
      out_q     <= 1'b0;
      oe_n_q    <= 1'b1;
      taken_q   <= 1'b0;
    end else begin
      mode_q    <= mode_d;
      pulses_q  <= pulses_d;
      bit_cnt_q <= bit_cnt_d;
      framing_q <= framing_d;
      late_q    <= late_d;
      held_q    <= held_d;
      result_q  <= result_d;
      shift_q   <= shift_d;
      out_q     <= out_d;
      oe_n_q    <= oe_n_d;
      taken_q   <= taken_d;
    end
  end

  // power mode stays internal: no pin reflects it
  assign link.serial_result_out  = out_q;
  assign link.serial_result_oe_n = oe_n_q;
  assign sample_taken            = taken_q;

endmodule : adc_end

// >>> hw/host_end.sv
// host end: clock divider, strobe sequencing, frame capture and result FIFO
`include "convert_strobe_link_consts.svh"

// ----------------------------------------
// result FIFO
// ----------------------------------------
module fifo_buf #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wr_q, wr_d;
  logic [AW:0]      rd_q, rd_d;
  logic             push;
  logic             pop;

  assign in_ready  = (wr_q[AW-1:0] != rd_q[AW-1:0]) || (wr_q[AW] == rd_q[AW]);
  assign out_valid = wr_q != rd_q;
  assign out_data  = mem_q[rd_q[AW-1:0]];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_comb begin
    wr_d = push ? wr_q + 1'b1 : wr_q;
    rd_d = pop ? rd_q + 1'b1 : rd_q;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
    end
    if (push) begin
      mem_q[wr_q[AW-1:0]] <= in_data;
    end
  end
endmodule : fifo_buf

// ----------------------------------------
// host controller end
// ----------------------------------------
module host_end #(
  parameter int SETTLE_CYC = `SETTLE_CYC
) (
  input  wire logic                  core_clk,
  input  wire logic                  rst,
  convert_strobe_link_if.ctrl                  link,
  input  wire logic                  start_req,
  input  wire logic                  nap_req,
  input  wire logic                  sleep_req,
  input  wire logic                  wake_req,
  output convert_strobe_link_pkg::frame_t      frame_data,
  output logic                       frame_valid,
  input  wire logic                  frame_ready,
  output logic                       cmd_ready,
  output logic                       settled
);
  import convert_strobe_link_pkg::*;

  logic [1:0]  line_q;
  logic        fifo_in_ready;
  host_state_t st_q,      st_d;
  logic [3:0]  div_q,     div_d;
  logic [5:0]  bits_q,    bits_d;
  logic [2:0]  pulses_q,  pulses_d;
  logic [4:0]  gap_q,     gap_d;
  logic [15:0] settle_q,  settle_d;
  frame_t      shift_q,   shift_d;
  logic        sck_q,     sck_d;
  logic        convert_strobe_q,    convert_strobe_d;
  logic        push_q,    push_d;
  logic        down_q,    down_d;
  logic        asleep_q,  asleep_d;
  logic        discard_q, discard_d;
  logic        settled_q, settled_d;
  logic        idle_q,    idle_d;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      line_q <= 2'b00;
    end else begin
      line_q <= {line_q[0], link.serial_line};
    end
  end

  always_comb begin
    st_d      = st_q;
    div_d     = (div_q == 4'd0) ? 4'd0 : div_q - 4'd1;
    bits_d    = bits_q;
    pulses_d  = pulses_q;
    gap_d     = (gap_q == `THROUGHPUT_CYC) ? gap_q : gap_q + 5'd1;
    settle_d  = settle_q;
    shift_d   = shift_q;
    sck_d     = sck_q;
    convert_strobe_d    = convert_strobe_q;
    push_d    = 1'b0;
    down_d    = down_q;
    asleep_d  = asleep_q;
    discard_d = discard_q;
    settled_d = settled_q;
    idle_d    = 1'b0;
    case (st_q)
      h_idle: begin
        idle_d = 1'b1;
        if (wake_req && down_q) begin
          sck_d  = 1'b1;
          div_d  = `SCK_HALF_CYC - 4'd1;
          idle_d = 1'b0;
          st_d   = h_wake_hi;
        end else if ((sleep_req || nap_req) && !down_q) begin
          pulses_d = sleep_req ? `SLEEP_PULSES : `NAP_PULSES;
          convert_strobe_d   = 1'b1;
          div_d    = `PD_PULSE_CYC - 4'd1;
          asleep_d = sleep_req;
          idle_d   = 1'b0;
          st_d     = h_pd_hi;
        end else if (start_req && !down_q && settled_q && fifo_in_ready && gap_q == `THROUGHPUT_CYC) begin
          convert_strobe_d = 1'b1;
          gap_d  = 5'd0;
          bits_d = 6'd0;
          div_d  = `SCK_HALF_CYC - 4'd1;
          idle_d = 1'b0;
          st_d   = h_lead;
        end
      end
      h_lead, h_low: begin
        if (div_q == 4'd0) begin
          sck_d   = 1'b1;
          convert_strobe_d  = 1'b0;
          shift_d = {shift_q[30:0], line_q[1]};
          bits_d  = bits_q + 6'd1;
          div_d   = `SCK_HALF_CYC - 4'd1;
          st_d    = h_high;
        end
      end
      h_high: begin
        if (div_q == 4'd0) begin
          sck_d = 1'b0;
          div_d = `SCK_HALF_CYC - 4'd1;
          st_d  = h_low;
          if (bits_q == `FRAME_BITS) begin
            // first frame after reset or wake is stale
            push_d    = !discard_q;
            discard_d = 1'b0;
            div_d     = `ACQ_CYC;
            st_d      = h_acq;
          end
        end
      end
      h_acq: begin
        if (div_q == 4'd0) begin
          st_d = h_idle;
        end
      end
      h_pd_hi: begin
        if (div_q == 4'd0) begin
          convert_strobe_d = 1'b0;
          div_d  = `PD_PULSE_CYC - 4'd1;
          st_d   = h_pd_lo;
        end
      end
      h_pd_lo: begin
        if (div_q == 4'd0) begin
          if (pulses_q == 3'd1) begin
            down_d = 1'b1;
            st_d   = h_idle;
          end else begin
            pulses_d = pulses_q - 3'd1;
            convert_strobe_d   = 1'b1;
            div_d    = `PD_PULSE_CYC - 4'd1;
            st_d     = h_pd_hi;
          end
        end
      end
      h_wake_hi: begin
        if (div_q == 4'd0) begin
          sck_d = 1'b0;
          div_d = `SCK_HALF_CYC - 4'd1;
          st_d  = h_wake_lo;
        end
      end
      h_wake_lo: begin
        if (div_q == 4'd0) begin
          down_d    = 1'b0;
          discard_d = 1'b1;
          settle_d  = 16'(SETTLE_CYC);
          settled_d = !asleep_q;
          st_d      = asleep_q ? h_settle : h_idle;
        end
      end
      h_settle: begin
        settle_d = settle_q - 16'd1;
        if (settle_q <= 16'd1) begin
          settled_d = 1'b1;
          asleep_d  = 1'b0;
          st_d      = h_idle;
        end
      end
      default: begin
        st_d = h_idle;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_q      <= h_idle;
      div_q     <= 4'd0;
      bits_q    <= 6'd0;
      pulses_q  <= 3'd0;
      gap_q     <= `THROUGHPUT_CYC;
      settle_q  <= 16'd0;
      shift_q   <= '0;
      sck_q     <= 1'b0;
      convert_strobe_q    <= 1'b0;
      push_q    <= 1'b0;
      down_q    <= 1'b0;
      asleep_q  <= 1'b0;
      discard_q <= 1'b1;
      settled_q <= 1'b1;
      idle_q    <= 1'b0;
    end else begin
      st_q      <= st_d;
      div_q     <= div_d;
      bits_q    <= bits_d;
      pulses_q  <= pulses_d;
      gap_q     <= gap_d;
      settle_q  <= settle_d;
      shift_q   <= shift_d;
      sck_q     <= sck_d;
      convert_strobe_q    <= convert_strobe_d;
      push_q    <= push_d;
      down_q    <= down_d;
      asleep_q  <= asleep_d;
      discard_q <= discard_d;
      settled_q <= settled_d;
      idle_q    <= idle_d;
    end
  end

  // space is checked before a frame starts, so the push is never refused
  fifo_buf #(.WIDTH(32), .DEPTH(16)) u_fifo (
    .core_clk  (core_clk),
    .rst       (rst),
    .in_data   (shift_q),
    .in_valid  (push_q),
    .in_ready  (fifo_in_ready),
    .out_data  (frame_data),
    .out_valid (frame_valid),
    .out_ready (frame_ready)
  );

  assign link.serial_clk     = sck_q;
  assign link.convert_strobe = convert_strobe_q;
  assign cmd_ready           = idle_q;
  assign settled             = settled_q;

endmodule : host_end

// >>> test/convert_strobe_link_assertions.sv
// timing checks on the three-wire link between host end and converter end
module convert_strobe_link_assertions (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic convert_strobe,
  input wire logic serial_clk,
  input wire logic serial_result_out,
  input wire logic serial_result_oe_n
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // helper counters
  // ----------------------------------------
  logic       strobe_q, sclk_q, out_q;
  logic [2:0] pulses_q, pulses_d;
  logic [5:0] rises_q, rises_d;
  logic [4:0] gap_q, gap_d;
  logic [1:0] chg_q, chg_d;
  logic [8:0] lvl_q, lvl_d;
  logic       st_rise, sck_rise, sck_edge;

  always_comb begin
    st_rise  = convert_strobe & ~strobe_q;
    sck_rise = serial_clk & ~sclk_q;
    sck_edge = serial_clk ^ sclk_q;
    pulses_d = sck_edge ? 3'h0 : (st_rise && pulses_q != 3'h7) ? pulses_q + 3'h1 : pulses_q;
    rises_d  = st_rise ? 6'h0 : (sck_rise && rises_q != 6'h3f) ? rises_q + 6'h1 : rises_q;
    gap_d    = (st_rise && pulses_q == 3'h0) ? 5'h0 : (gap_q != 5'h1f) ? gap_q + 5'h1 : gap_q;
    // output changes seen since the last clock rise, only while driven
    chg_d    = sck_rise ? 2'h0 : (!serial_result_oe_n && serial_result_out != out_q && chg_q != 2'h3) ?
               chg_q + 2'h1 : chg_q;
    lvl_d    = sck_edge ? 9'h0 : (lvl_q != 9'h1ff) ? lvl_q + 9'h1 : lvl_q;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      {strobe_q, sclk_q, out_q} <= 3'h0;
      pulses_q <= 3'h0;
      rises_q  <= 6'h0;
      gap_q    <= 5'h1f;
      chg_q    <= 2'h0;
      lvl_q    <= 9'h0;
    end else begin
      {strobe_q, sclk_q, out_q} <= {convert_strobe, serial_clk, serial_result_out};
      pulses_q <= pulses_d;
      rises_q  <= rises_d;
      gap_q    <= gap_d;
      chg_q    <= chg_d;
      lvl_q    <= lvl_d;
    end
  end

  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  chk_start_drives_line:
    assert property ($rose(convert_strobe) && pulses_q == 3'h0 |-> ##[1:8] !serial_result_oe_n)
    else $error("output not enabled after a conversion start");
  chk_release_after_frame:
    assert property ($rose(serial_clk) && rises_q == 6'h1f |-> ##[1:8] serial_result_oe_n)
    else $error("output not released after the last bit");
  chk_no_start_down:
    assert property ($rose(convert_strobe) && pulses_q >= 3'h2 |-> ##1 (!$fell(serial_result_oe_n)) [*8])
    else $error("strobe in power-down started a readout");
  chk_one_bit_rise:
    assert property (!serial_result_oe_n |-> chg_q <= 2'h1)
    else $error("output changed twice within one clock");
  chk_start_spacing:
    assert property ($rose(convert_strobe) && pulses_q == 3'h0 |-> gap_q >= 5'hd)
    else $error("conversion starts closer than the minimum period");
  chk_acq_gap:
    assert property ($rose(serial_clk) && rises_q == 6'h1f |-> !$rose(convert_strobe))
    else $error("no acquisition time after the last clock");
  chk_clk_period:
    assert property (rises_q != 6'h0 && rises_q < 6'h20 |-> lvl_q < 9'hc8)
    else $error("serial clock too slow during conversion");
  chk_strobe_lead:
    assert property ($rose(convert_strobe) |-> (!$rose(serial_clk)) [*4])
    else $error("clock rise too close after the strobe");
endmodule : convert_strobe_link_assertions

// >>> test/testbench.sv
// bench: host and converter ends joined, plus a narrow converter clocked by hand
module testbench import convert_strobe_link_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  logic   core_clk, rst, start_req, nap_req, sleep_req, wake_req, frame_ready;
  logic   frame_valid, cmd_ready, settled, ch0_over, ch0_under, ch1_over, ch1_under, taken_a;
  code_t  ch0_code, ch1_code, b0_code, b1_code;
  frame_t frame_data;
  int     miscompares, n_tests;
  convert_strobe_link_if link_if ();
  convert_strobe_link_if bx_if ();

  host_end #(.SETTLE_CYC(20)) host_end_inst (.core_clk(core_clk), .rst(rst), .link(link_if.ctrl),
    .start_req(start_req), .nap_req(nap_req), .sleep_req(sleep_req), .wake_req(wake_req),
    .frame_data(frame_data), .frame_valid(frame_valid), .frame_ready(frame_ready), .cmd_ready(cmd_ready),
    .settled(settled));
  adc_end #(.WIDE_RES(1'b1)) adc_end_inst (.core_clk(core_clk), .rst(rst), .link(link_if.adc),
    .ch0_code(ch0_code), .ch1_code(ch1_code), .ch0_over(ch0_over), .ch0_under(ch0_under),
    .ch1_over(ch1_over), .ch1_under(ch1_under), .sample_taken(taken_a));
  adc_end #(.WIDE_RES(1'b0)) adc_end_inst_b (.core_clk(core_clk), .rst(rst), .link(bx_if.adc),
    .ch0_code(b0_code), .ch1_code(b1_code), .ch0_over(ch0_over), .ch0_under(ch0_under),
    .ch1_over(ch1_over), .ch1_under(ch1_under), .sample_taken());
  convert_strobe_link_assertions convert_strobe_link_assertions_inst (.core_clk(core_clk), .rst(rst),
    .convert_strobe(link_if.convert_strobe), .serial_clk(link_if.serial_clk),
    .serial_result_out(link_if.serial_result_out), .serial_result_oe_n(link_if.serial_result_oe_n));

  always #25 core_clk = ~core_clk;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #5;
  endtask : cyc

  task automatic chk32(input frame_t got, input frame_t exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk32

  task automatic chk1(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk1

  function automatic frame_t pair(input code_t a, input code_t b, input logic wide);
    pair = wide ? {2'h0, a, 2'h0, b} : {2'h0, a[11:0], 2'h0, 2'h0, b[11:0], 2'h0};
  endfunction : pair

  // hold a request until the host leaves idle
  task automatic issue(ref logic r);
    for (int i = 0; i < 2000 && cmd_ready !== 1'b1; i++) cyc(1);
    r = 1'b1;
    for (int i = 0; i < 40 && cmd_ready !== 1'b0; i++) cyc(1);
    r = 1'b0;
    chk1(cmd_ready, 1'b0);
  endtask : issue

  // inputs may only change once the converter has held them
  task automatic start_convert_strobe();
    issue(start_req);
    for (int i = 0; i < 8 && taken_a !== 1'b1; i++) cyc(1);
    chk1(taken_a, 1'b1);
  endtask : start_convert_strobe

  task automatic pop(input frame_t exp);
    cyc(1);
    for (int i = 0; i < 1200 && frame_valid !== 1'b1; i++) cyc(1);
    chk32(frame_data, exp);
    frame_ready = 1'b1;
    cyc(1);
    frame_ready = 1'b0;
  endtask : pop

  // sample before each rise: the previous bit is still valid there
  task automatic bx_frame(input logic late, input logic judge, input frame_t exp);
    frame_t got;
    bx_if.convert_strobe = 1'b1;
    bx_if.serial_clk = late;
    cyc(4);
    bx_if.convert_strobe = 1'b0;
    bx_if.serial_clk = 1'b0;
    cyc(4);
    // a late start costs one extra rise before the first shift
    for (int k = 31 + late; k >= 0; k--) begin
      if (k < 32) got[k] = bx_if.serial_line;
      bx_if.serial_clk = 1'b1;
      cyc(4);
      bx_if.serial_clk = 1'b0;
      cyc(4);
    end
    chk1(bx_if.serial_result_oe_n, 1'b1);
    if (judge) chk32(got, exp);
  endtask : bx_frame

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic sc_latency();
    ch0_code = 14'h1234;
    ch1_code = 14'h2bcd;
    start_convert_strobe();
    ch0_code = 14'h0f0f;
    ch1_code = 14'h3001;
    start_convert_strobe();
    pop(pair(14'h1234, 14'h2bcd, 1'b1));
    {ch0_over, ch1_under} = 2'h3;
    issue(start_req);
    pop(pair(14'h0f0f, 14'h3001, 1'b1));
    {ch0_over, ch1_under, ch0_under, ch1_over} = 4'h3;
    issue(start_req);
    pop(32'h3fff_0000);
    {ch0_under, ch1_over} = 2'h0;
    issue(start_req);
    pop(32'h0000_3fff);
  endtask : sc_latency

  task automatic sc_fifo();
    logic moved;
    moved = 1'b0;
    for (int k = 0; k < 16; k++) issue(start_req);
    cyc(600);
    start_req = 1'b1;
    repeat (600) begin
      cyc(1);
      moved = moved | link_if.serial_clk;
    end
    start_req = 1'b0;
    chk1(moved, 1'b0);
    for (int k = 0; k < 16; k++) pop(pair(14'h0f0f, 14'h3001, 1'b1));
    cyc(2);
    chk1(frame_valid, 1'b0);
  endtask : sc_fifo

  task automatic sc_power();
    issue(nap_req);
    issue(wake_req);
    chk1(settled, 1'b1);
    ch0_code = 14'h2222;
    ch1_code = 14'h0555;
    issue(start_req);
    issue(start_req);
    pop(pair(14'h2222, 14'h0555, 1'b1));
    issue(sleep_req);
    issue(wake_req);
    for (int i = 0; i < 40 && settled !== 1'b0; i++) cyc(1);
    chk1(settled, 1'b0);
    for (int i = 0; i < 200 && settled !== 1'b1; i++) cyc(1);
    chk1(settled, 1'b1);
    ch0_code = 14'h3ffe;
    issue(start_req);
    issue(start_req);
    pop(pair(14'h3ffe, 14'h0555, 1'b1));
  endtask : sc_power

  task automatic sc_late();
    b0_code = 14'h3abc;
    b1_code = 14'h0123;
    bx_frame(1'b0, 1'b1, 32'h0);
    b0_code = 14'h1555;
    b1_code = 14'h2aaa;
    bx_frame(1'b1, 1'b1, pair(14'h3abc, 14'h0123, 1'b0));
    bx_frame(1'b0, 1'b1, pair(14'h1555, 14'h2aaa, 1'b0));
  endtask : sc_late

  task automatic test_done();
    $display("compares %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : test_done

  initial begin
    repeat (40000) @(posedge core_clk);
    miscompares++;
    test_done();
  end

  initial begin
    {core_clk, rst, start_req, nap_req, sleep_req, wake_req, frame_ready} = 7'h20;
    {ch0_over, ch0_under, ch1_over, ch1_under} = 4'h0;
    {ch0_code, ch1_code, b0_code, b1_code} = '0;
    {bx_if.convert_strobe, bx_if.serial_clk} = 2'h0;
    miscompares = 0;
    n_tests = 0;
    cyc(16);
    rst = 1'b0;
    sc_latency();
    sc_fifo();
    sc_power();
    sc_late();
    test_done();
  end
endmodule : testbench
